//--- logic/ppfs_defs.svh
// Purpose: Constants for the port pin function select block.
// Assumes: Included by bare name from the design files.
// Notes: Pin indices follow the per-port bit positions.
`ifndef PPFS_DEFS_SVH
`define PPFS_DEFS_SVH

// ==========================================================
// Port widths and pin positions
`define PPFS_P1_WIDTH 8
`define PPFS_P2_WIDTH 8
`define PPFS_P3_WIDTH 8
`define PPFS_PJ_WIDTH 7
`define PPFS_P1_UA_CLK 3'h0
`define PPFS_P1_UB_SDA 3'h4
`define PPFS_P1_UB_SCL 3'h5
`define PPFS_PJ_TDO 3'h0
`define PPFS_PJ_TDI 3'h1
`define PPFS_PJ_TMS 3'h2
`define PPFS_PJ_TCK 3'h3
`define PPFS_PJ_OSCILLATOR_OUTPUT_PIN 3'h4
`define PPFS_PJ_XIN 3'h5
// Oscillator input pin select sits at bit 5 of the port J select bits.
`define PPFS_OSC_SEL_BIT 3'h5
// Serial unit B SPI wire mode encodings.
`define PPFS_SPI_3WIRE 1'h0
`define PPFS_SPI_4WIRE 1'h1

`endif

//--- logic/ppfs_pkg.sv
// Purpose: Types for the port pin function select block.
// Assumes: Nothing beyond the defs header.
// Notes: Holds the pin mode enumeration only.
package ppfs_pkg;

	// ==========================================================
	// Pin operating mode as resolved from the control bits.
	typedef enum logic [1:0] {
		PPFS_GPIO_IN = 2'b00,
		PPFS_GPIO_OUT = 2'b01,
		PPFS_PERIPH_IN = 2'b10,
		PPFS_PERIPH_OUT = 2'b11
	} ppfs_mode_type;

endpackage

//--- logic/ppfs_pin_cell.sv
// Purpose: One pin's function select: GPIO or peripheral, in or out.
// Assumes: Inputs synchronous to clock.
// Notes: Outputs are registered; overrides come from the top module.
`timescale 1ns/1ps
`include "ppfs_defs.svh"

module ppfs_pin_cell
	import ppfs_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic dir_bit,
	input wire logic sel_bit,
	input wire logic gpio_out,
	input wire logic periph_out,
	input wire logic periph_oe_own,
	input wire logic use_periph_oe,
	input wire logic open_drain,
	input wire logic force_off,
	input wire logic pin_in,
	input wire logic periph_in_enable,
	output logic pin_out,
	output logic pin_oe,
	output logic gpio_in,
	output logic periph_in
);

	// ==========================================================
	// Mode decode
	ppfs_mode_type mode;
	logic next_pin_out;
	logic next_pin_oe;
	logic next_gpio_in;
	logic next_periph_in;
	logic raw_out;
	logic raw_oe;

	// Select and direction bits pick the mode of the pin.
	assign mode = ppfs_mode_type'({sel_bit, dir_bit}); // R1

	// Next pin state; a unit that owns its own enable overrides direction.
	always_comb begin
		raw_out = 1'b0;
		raw_oe = 1'b0;
		unique case (mode)
			PPFS_GPIO_IN: begin
				raw_oe = 1'b0; // R1
			end
			PPFS_GPIO_OUT: begin
				raw_out = gpio_out; // R1
				raw_oe = 1'b1;
			end
			PPFS_PERIPH_IN: begin
				raw_out = periph_out;
				raw_oe = use_periph_oe & periph_oe_own; // R2
			end
			PPFS_PERIPH_OUT: begin
				raw_out = periph_out; // R1
				raw_oe = use_periph_oe ? periph_oe_own : 1'b1; // R2
			end
		endcase
		// Open drain only pulls low, so a high level releases the pin.
		next_pin_oe = raw_oe & ~force_off & (~open_drain | ~raw_out); // R4
		// A blocked pin also sets its output low with its enable off, so no stale level sits on a pad it no longer owns.
		next_pin_out = (open_drain | force_off) ? 1'b0 : raw_out; // R4
		next_gpio_in = pin_in & ~sel_bit & ~force_off;
		next_periph_in = pin_in & sel_bit & ~dir_bit & periph_in_enable; // R10 R11
	end

	// Registered outputs keep the pad drive glitch free.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
			gpio_in <= 1'b0;
			periph_in <= 1'b0;
		end else begin
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
			gpio_in <= next_gpio_in;
			periph_in <= next_periph_in;
		end
	end

endmodule

//--- logic/ppfs_top.sv
// Purpose: Pin function select for ports 1, 2, 3 and J.
// Assumes: One 100 MHz clock, synchronous active high reset.
// Notes: All outputs come from flip-flops, one cycle after inputs.
// Overview of operation
// R1: Select and direction pick GPIO or peripheral.
// R2: Serial unit drives its own pin enable.
// R3: Unit A clock wins; unit B forced 3-wire.
// R4: I2C pins only drive low, else release.
// R5: Test-port mode gives debug pins to test port.
// R6: Test-port mode forces pull-ups on TMS, TCK, TDI.
// R7: Oscillator select disables GPIO on both pins.
// R8: Bypass mode frees oscillator output pin GPIO.
// R9: Bypass bit chooses crystal or external clock.
// R10: Timer-0 clear and faults gated by its enables.
// R11: Timer-1 clear and faults gated by its enables.
`timescale 1ns/1ps
`include "ppfs_defs.svh"

module ppfs_top
	import ppfs_pkg::*;
#(
	parameter int P1_WIDTH = `PPFS_P1_WIDTH,
	parameter int P2_WIDTH = `PPFS_P2_WIDTH,
	parameter int P3_WIDTH = `PPFS_P3_WIDTH,
	parameter int PJ_WIDTH = `PPFS_PJ_WIDTH
)
(
	input wire logic clock,
	input wire logic sys_rst,
	// Port 1 control and pins.
	input wire logic [P1_WIDTH-1:0] p1_port_direction_bit,
	input wire logic [P1_WIDTH-1:0] p1_port_function_select_bit,
	input wire logic [P1_WIDTH-1:0] p1_gpio_out,
	input wire logic [P1_WIDTH-1:0] p1_periph_out,
	input wire logic [P1_WIDTH-1:0] p1_periph_oe,
	input wire logic [P1_WIDTH-1:0] p1_pin_in,
	output logic [P1_WIDTH-1:0] p1_pin_out,
	output logic [P1_WIDTH-1:0] p1_pin_oe,
	output logic [P1_WIDTH-1:0] p1_gpio_in,
	output logic [P1_WIDTH-1:0] p1_periph_in,
	// Serial units: I2C selection and unit B wire mode request.
	input wire logic serial_unit_b_i2c_mode,
	input wire logic serial_unit_b_spi_mode_req,
	output logic serial_unit_b_spi_mode,
	// Port 2 control and pins.
	input wire logic [P2_WIDTH-1:0] p2_port_direction_bit,
	input wire logic [P2_WIDTH-1:0] p2_port_function_select_bit,
	input wire logic [P2_WIDTH-1:0] p2_gpio_out,
	input wire logic [P2_WIDTH-1:0] p2_periph_out,
	input wire logic [P2_WIDTH-1:0] p2_pin_in,
	output logic [P2_WIDTH-1:0] p2_pin_out,
	output logic [P2_WIDTH-1:0] p2_pin_oe,
	output logic [P2_WIDTH-1:0] p2_gpio_in,
	output logic [P2_WIDTH-1:0] p2_periph_in,
	// Port 3 control and pins.
	input wire logic [P3_WIDTH-1:0] p3_port_direction_bit,
	input wire logic [P3_WIDTH-1:0] p3_port_function_select_bit,
	input wire logic [P3_WIDTH-1:0] p3_gpio_out,
	input wire logic [P3_WIDTH-1:0] p3_periph_out,
	input wire logic [P3_WIDTH-1:0] p3_pin_in,
	output logic [P3_WIDTH-1:0] p3_pin_out,
	output logic [P3_WIDTH-1:0] p3_pin_oe,
	output logic [P3_WIDTH-1:0] p3_gpio_in,
	output logic [P3_WIDTH-1:0] p3_periph_in,
	// Timer event control input enables, per pin of ports 2 and 3.
	input wire logic [P2_WIDTH-1:0] p2_event_input_enable,
	input wire logic [P3_WIDTH-1:0] p3_event_input_enable,
	// Port J control and pins.
	input wire logic [PJ_WIDTH-1:0] pj_port_direction_bit,
	input wire logic [PJ_WIDTH-1:0] pj_port_function_select_bit,
	input wire logic [PJ_WIDTH-1:0] pj_pull_resistor_enable_bit,
	input wire logic [PJ_WIDTH-1:0] pj_gpio_out,
	input wire logic [PJ_WIDTH-1:0] pj_periph_out,
	input wire logic [PJ_WIDTH-1:0] pj_pin_in,
	output logic [PJ_WIDTH-1:0] pj_pin_out,
	output logic [PJ_WIDTH-1:0] pj_pin_oe,
	output logic [PJ_WIDTH-1:0] pj_pull_enable,
	output logic [PJ_WIDTH-1:0] pj_gpio_in,
	output logic [PJ_WIDTH-1:0] pj_periph_in,
	// Debug test port.
	input wire logic test_port_mode,
	input wire logic test_port_tdo_out,
	input wire logic test_port_tdo_oe,
	output logic test_port_tdi,
	output logic test_port_tms,
	output logic test_port_tck,
	// Oscillator.
	input wire logic oscillator_bypass_enable,
	output logic osc_crystal_mode,
	output logic osc_bypass_mode,
	output logic osc_ext_clock_in
);

	// ==========================================================
	// Overrides on shared and special pins
	logic [P1_WIDTH-1:0] p1_od;
	logic [PJ_WIDTH-1:0] pj_off;
	logic [PJ_WIDTH-1:0] pj_tp;
	logic [PJ_WIDTH-1:0] pj_cell_dir;
	logic [PJ_WIDTH-1:0] pj_cell_gpio_out;
	logic [PJ_WIDTH-1:0] pj_cell_pin_in;
	logic osc_sel;
	logic ua_clk_used;

	// The oscillator input pin select bit hands the crystal pins to the oscillator.
	assign osc_sel = pj_port_function_select_bit[`PPFS_OSC_SEL_BIT]; // R9

	// Only the two unit B data and clock pins go open drain in I2C use.
	// A pin left on GPIO keeps its push-pull drive even while the unit runs I2C.
	always_comb begin
		p1_od = '0;
		p1_od[`PPFS_P1_UB_SDA] = serial_unit_b_i2c_mode; // R4
		p1_od[`PPFS_P1_UB_SCL] = serial_unit_b_i2c_mode; // R4
		p1_od = p1_od & p1_port_function_select_bit; // R4
	end

	// The shared clock pin counts as unit A clock whenever it is selected.
	assign ua_clk_used = p1_port_function_select_bit[`PPFS_P1_UA_CLK]; // R3

	// Debug pins held by the test port, crystal pins held by the oscillator.
	always_comb begin
		pj_tp = '0;
		pj_tp[`PPFS_PJ_TDO] = test_port_mode; // R5
		pj_tp[`PPFS_PJ_TDI] = test_port_mode; // R5
		pj_tp[`PPFS_PJ_TMS] = test_port_mode; // R5
		pj_tp[`PPFS_PJ_TCK] = test_port_mode; // R5
		pj_off = '0;
		pj_off[`PPFS_PJ_XIN] = osc_sel; // R7
		pj_off[`PPFS_PJ_OSCILLATOR_OUTPUT_PIN] = osc_sel & ~oscillator_bypass_enable; // R7 R8
	end

	// In test-port mode the debug pins run as plain I/O under the test port's
	// enable and data, so the cell flops drive the pads with no mux behind them.
	always_comb begin
		pj_cell_dir = pj_port_direction_bit;
		pj_cell_gpio_out = pj_gpio_out;
		pj_cell_pin_in = pj_pin_in & ~(pj_tp | pj_off);
		if (test_port_mode) begin
			pj_cell_dir[`PPFS_PJ_TDI] = 1'b0; // R5
			pj_cell_dir[`PPFS_PJ_TMS] = 1'b0; // R5
			pj_cell_dir[`PPFS_PJ_TCK] = 1'b0; // R5
			pj_cell_dir[`PPFS_PJ_TDO] = test_port_tdo_oe; // R5
			pj_cell_gpio_out[`PPFS_PJ_TDO] = test_port_tdo_out; // R5
		end
	end

	// ==========================================================
	// Pin cells
	genvar i;
	generate
		for (i = 0; i < P1_WIDTH; i++) begin : g_p1
			ppfs_pin_cell u_cell (
				.clock(clock), .sys_rst(sys_rst),
				.dir_bit(p1_port_direction_bit[i]),
				.sel_bit(p1_port_function_select_bit[i]),
				.gpio_out(p1_gpio_out[i]), .periph_out(p1_periph_out[i]),
				.periph_oe_own(p1_periph_oe[i]), .use_periph_oe(i < 6), // R1 R2
				.open_drain(p1_od[i]), .force_off(1'b0),
				.pin_in(p1_pin_in[i]), .periph_in_enable(1'b1),
				.pin_out(p1_pin_out[i]), .pin_oe(p1_pin_oe[i]),
				.gpio_in(p1_gpio_in[i]), .periph_in(p1_periph_in[i])
			);
		end
		for (i = 0; i < P2_WIDTH; i++) begin : g_p2
			ppfs_pin_cell u_cell (
				.clock(clock), .sys_rst(sys_rst),
				.dir_bit(p2_port_direction_bit[i]),
				.sel_bit(p2_port_function_select_bit[i]),
				.gpio_out(p2_gpio_out[i]), .periph_out(p2_periph_out[i]),
				.periph_oe_own(1'b0), .use_periph_oe(1'b0),
				.open_drain(1'b0), .force_off(1'b0),
				.pin_in(p2_pin_in[i]), .periph_in_enable(p2_event_input_enable[i]),
				.pin_out(p2_pin_out[i]), .pin_oe(p2_pin_oe[i]),
				.gpio_in(p2_gpio_in[i]), .periph_in(p2_periph_in[i])
			);
		end
		for (i = 0; i < P3_WIDTH; i++) begin : g_p3
			ppfs_pin_cell u_cell (
				.clock(clock), .sys_rst(sys_rst),
				.dir_bit(p3_port_direction_bit[i]),
				.sel_bit(p3_port_function_select_bit[i]),
				.gpio_out(p3_gpio_out[i]), .periph_out(p3_periph_out[i]),
				.periph_oe_own(1'b0), .use_periph_oe(1'b0),
				.open_drain(1'b0), .force_off(1'b0),
				.pin_in(p3_pin_in[i]), .periph_in_enable(p3_event_input_enable[i]),
				.pin_out(p3_pin_out[i]), .pin_oe(p3_pin_oe[i]),
				.gpio_in(p3_gpio_in[i]), .periph_in(p3_periph_in[i])
			);
		end
		for (i = 0; i < PJ_WIDTH; i++) begin : g_pj
			ppfs_pin_cell u_cell (
				.clock(clock), .sys_rst(sys_rst),
				.dir_bit(pj_cell_dir[i]),
				.sel_bit(pj_port_function_select_bit[i] & (i < 4 || i == 6) & ~pj_tp[i]), // R5
				.gpio_out(pj_cell_gpio_out[i]), .periph_out(pj_periph_out[i]),
				.periph_oe_own(1'b0), .use_periph_oe(1'b0),
				.open_drain(1'b0), .force_off(pj_off[i]),
				.pin_in(pj_cell_pin_in[i]), .periph_in_enable(~pj_off[i]),
				.pin_out(pj_pin_out[i]), .pin_oe(pj_pin_oe[i]),
				.gpio_in(pj_gpio_in[i]), .periph_in(pj_periph_in[i])
			);
		end
	endgenerate

	// ==========================================================
	// Port J, test port and oscillator registers
	logic [PJ_WIDTH-1:0] next_pj_pull;
	logic next_spi_mode;
	logic next_tdi;
	logic next_tms;
	logic next_tck;
	logic next_xtal;
	logic next_bypass;
	logic next_ext_clk;

	// Test-port pulls, wire-mode force and oscillator mode decode.
	always_comb begin
		next_pj_pull = pj_pull_resistor_enable_bit;
		if (test_port_mode) begin
			next_pj_pull[`PPFS_PJ_TDI] = 1'b1; // R6
			next_pj_pull[`PPFS_PJ_TMS] = 1'b1; // R6
			next_pj_pull[`PPFS_PJ_TCK] = 1'b1; // R6
		end
		// The clock use wins, so unit B cannot keep its 4-wire select.
		next_spi_mode = ua_clk_used ? `PPFS_SPI_3WIRE : serial_unit_b_spi_mode_req; // R3
		next_tdi = test_port_mode & pj_pin_in[`PPFS_PJ_TDI]; // R5
		next_tms = test_port_mode & pj_pin_in[`PPFS_PJ_TMS]; // R5
		next_tck = test_port_mode & pj_pin_in[`PPFS_PJ_TCK]; // R5
		next_xtal = osc_sel & ~oscillator_bypass_enable; // R9
		next_bypass = osc_sel & oscillator_bypass_enable; // R9
		next_ext_clk = next_bypass & pj_pin_in[`PPFS_PJ_XIN]; // R9
	end

	// Register the side signals; outputs come straight from the registers, with no mux after them.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pj_pull_enable <= '0;
			serial_unit_b_spi_mode <= `PPFS_SPI_3WIRE;
			test_port_tdi <= 1'b0;
			test_port_tms <= 1'b0;
			test_port_tck <= 1'b0;
			osc_crystal_mode <= 1'b0;
			osc_bypass_mode <= 1'b0;
			osc_ext_clock_in <= 1'b0;
		end else begin
			pj_pull_enable <= next_pj_pull;
			serial_unit_b_spi_mode <= next_spi_mode;
			test_port_tdi <= next_tdi;
			test_port_tms <= next_tms;
			test_port_tck <= next_tck;
			osc_crystal_mode <= next_xtal;
			osc_bypass_mode <= next_bypass;
			osc_ext_clock_in <= next_ext_clk;
		end
	end

endmodule

//--- test/ppfs_periph_model.sv
// Purpose: Model of the peripherals and the test port behind the pins.
// Assumes: Shares the bench clock.
// Notes: Levels change every cycle, which is harsher than most real units.
`timescale 1ns/1ps
module ppfs_periph_model (
	input wire logic clock,
	output logic [7:0] p1_periph_out = 8'h00,
	output logic [7:0] p1_periph_oe = 8'h00,
	output logic [7:0] p2_periph_out = 8'h00,
	output logic [7:0] p3_periph_out = 8'h00,
	output logic [6:0] pj_periph_out = 7'h00,
	output logic [7:0] p2_event_input_enable = 8'h00,
	output logic [7:0] p3_event_input_enable = 8'h00,
	output logic test_port_tdo_out = 1'h0,
	output logic test_port_tdo_oe = 1'h0
);
	// ==========================================================
	// Units drive their own data and enables, and gate their clear and fault inputs.
	always @(posedge clock) begin
		{p1_periph_out, p1_periph_oe, p2_periph_out, p3_periph_out} <= $urandom;
		{pj_periph_out, p2_event_input_enable, p3_event_input_enable} <= 23'($urandom);
		{test_port_tdo_out, test_port_tdo_oe} <= 2'($urandom);
	end
endmodule

//--- test/ppfs_top_props.sv
// Purpose: Port-level properties of the pin function select block.
// Assumes: Every output lags its inputs by one clock edge.
// Notes: The first edge after reset is skipped, since outputs still hold reset values.
`timescale 1ns/1ps
module ppfs_top_props (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] p1_port_direction_bit,
	input wire logic [7:0] p1_port_function_select_bit,
	input wire logic [7:0] p1_periph_oe,
	input wire logic [7:0] p1_periph_out,
	input wire logic [7:0] p2_port_function_select_bit,
	input wire logic [7:0] p2_event_input_enable,
	input wire logic [7:0] p2_pin_in,
	input wire logic [7:0] p2_periph_in,
	input wire logic [7:0] p1_pin_out,
	input wire logic [7:0] p1_pin_oe,
	input wire logic serial_unit_b_i2c_mode,
	input wire logic serial_unit_b_spi_mode_req,
	input wire logic serial_unit_b_spi_mode,
	input wire logic [7:0] p2_port_direction_bit,
	input wire logic [7:0] p2_pin_oe,
	input wire logic [7:0] p3_port_direction_bit,
	input wire logic [7:0] p3_port_function_select_bit,
	input wire logic [7:0] p3_event_input_enable,
	input wire logic [7:0] p3_pin_in,
	input wire logic [7:0] p3_periph_in,
	input wire logic test_port_mode,
	input wire logic test_port_tdo_oe,
	input wire logic [6:0] pj_port_direction_bit,
	input wire logic [6:0] pj_port_function_select_bit,
	input wire logic [6:0] pj_pull_resistor_enable_bit,
	input wire logic [6:0] pj_pin_oe,
	input wire logic [6:0] pj_pull_enable,
	input wire logic [6:0] pj_gpio_in,
	input wire logic oscillator_bypass_enable,
	input wire logic osc_crystal_mode,
	input wire logic osc_bypass_mode
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic ok = 1'h0;
	// ==========================================================
	// High when the previous edge was outside reset, so $past sees real inputs.
	always_ff @(posedge clock) ok <= !sys_rst;
	property p_dir;
		ok |-> p2_pin_oe == $past(p2_port_direction_bit);
	endproperty
	a_dir: assert property (p_dir) else $error("port 2 enable differs from direction");
	property p_tmr;
		ok && $past(p1_port_function_select_bit[7])
			|-> p1_pin_oe[7] == $past(p1_port_direction_bit[7]);
	endproperty
	a_tmr: assert property (p_tmr) else $error("timer pin enable not from direction");
	property p_uoe;
		ok && $past(p1_port_function_select_bit[1])
			|-> p1_pin_oe[1] == $past(p1_periph_oe[1]);
	endproperty
	a_uoe: assert property (p_uoe) else $error("serial pin enable not from unit");
	property p_spi;
		ok |-> serial_unit_b_spi_mode == $past(serial_unit_b_spi_mode_req && !p1_port_function_select_bit[0]);
	endproperty
	a_spi: assert property (p_spi) else $error("unit B wire mode wrong");
	property p_od;
		ok && $past(serial_unit_b_i2c_mode && p1_port_function_select_bit[5])
			|-> !p1_pin_out[5] && p1_pin_oe[5] == $past(p1_periph_oe[5] && !p1_periph_out[5]);
	endproperty
	a_od: assert property (p_od) else $error("open drain pin drives high");
	property p_tpo;
		ok && $past(test_port_mode) |-> pj_pin_oe[3:0] == {3'h0, $past(test_port_tdo_oe)};
	endproperty
	a_tpo: assert property (p_tpo) else $error("debug pin enable wrong");
	property p_pul;
		ok |-> pj_pull_enable[3:1] == ($past(test_port_mode) ? 3'h7
			: $past(pj_pull_resistor_enable_bit[3:1]));
	endproperty
	a_pul: assert property (p_pul) else $error("debug pin pull wrong");
	property p_xtl;
		ok && $past(pj_port_function_select_bit[5] && !oscillator_bypass_enable)
			|-> pj_pin_oe[5:4] == 2'h0 && pj_gpio_in[5:4] == 2'h0;
	endproperty
	a_xtl: assert property (p_xtl) else $error("crystal pins still in use as GPIO");
	property p_byp;
		ok && $past(pj_port_function_select_bit[5] && oscillator_bypass_enable)
			|-> pj_pin_oe[5:4] == {1'h0, $past(pj_port_direction_bit[4])};
	endproperty
	a_byp: assert property (p_byp) else $error("bypass output pin enable wrong");
	property p_osc;
		ok |-> {osc_crystal_mode, osc_bypass_mode}
			== $past({pj_port_function_select_bit[5] & !oscillator_bypass_enable,
			pj_port_function_select_bit[5] & oscillator_bypass_enable});
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator mode decode wrong");
	property p_ev0;
		ok |-> p2_periph_in[6:4] == $past(p2_port_function_select_bit[6:4]
			& ~p2_port_direction_bit[6:4] & p2_event_input_enable[6:4] & p2_pin_in[6:4]);
	endproperty
	a_ev0: assert property (p_ev0) else $error("timer 0 event input not gated");
	property p_evt;
		ok |-> p3_periph_in[1:0] == $past(p3_port_function_select_bit[1:0]
			& ~p3_port_direction_bit[1:0] & p3_event_input_enable[1:0] & p3_pin_in[1:0]);
	endproperty
	a_evt: assert property (p_evt) else $error("event input not gated");
endmodule
bind ppfs_top ppfs_top_props u_props (.*);

//--- test/tb_top.sv
// Purpose: Self-checking bench for the pin function select block.
// Assumes: Outputs follow inputs by exactly one clock edge.
// Notes: Random pin and control levels; the peripheral model adds its own.
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [7:0] p1oe, p1out, p1gin, p1pin, p2oe, p2out, p2gin, p2pin, p3oe, p3out, p3gin;
		logic [7:0] p3pin, pjoe, pjout, pjgin, pjpin, pjpull, misc;
	} ppfs_note_type;
	logic clock = 1'h0;
	logic sys_rst = 1'h1;
	logic [7:0] p1_port_direction_bit = 8'h00, p1_port_function_select_bit = 8'h00;
	logic [7:0] p1_gpio_out = 8'h00, p1_pin_in = 8'h00, p2_pin_in = 8'h00, p3_pin_in = 8'h00;
	logic [7:0] p2_port_direction_bit = 8'h00, p2_port_function_select_bit = 8'h00;
	logic [7:0] p3_port_direction_bit = 8'h00, p3_port_function_select_bit = 8'h00;
	logic [7:0] p2_gpio_out = 8'h00, p3_gpio_out = 8'h00;
	logic [6:0] pj_port_direction_bit = 7'h00, pj_port_function_select_bit = 7'h00;
	logic [6:0] pj_pull_resistor_enable_bit = 7'h00, pj_gpio_out = 7'h00, pj_pin_in = 7'h00;
	logic serial_unit_b_i2c_mode = 1'h0, serial_unit_b_spi_mode_req = 1'h0;
	logic test_port_mode = 1'h0, oscillator_bypass_enable = 1'h0;
	logic [7:0] p1_periph_out, p1_periph_oe, p2_periph_out, p3_periph_out;
	logic [7:0] p2_event_input_enable, p3_event_input_enable;
	logic [6:0] pj_periph_out, pj_pin_out, pj_pin_oe, pj_pull_enable, pj_gpio_in, pj_periph_in;
	logic [7:0] p1_pin_out, p1_pin_oe, p1_gpio_in, p1_periph_in, p2_pin_out, p2_pin_oe;
	logic [7:0] p2_gpio_in, p2_periph_in, p3_pin_out, p3_pin_oe, p3_gpio_in, p3_periph_in;
	logic test_port_tdo_out, test_port_tdo_oe, test_port_tdi, test_port_tms, test_port_tck;
	logic serial_unit_b_spi_mode, osc_crystal_mode, osc_bypass_mode, osc_ext_clock_in;
	ppfs_note_type note_q[$];
	int fail_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	ppfs_top dut (.*);
	ppfs_periph_model partner (.*);
	// ==========================================================
	// Clock and a hang limit well above the length of the sequence.
	initial begin
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 1500) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		samples_checked++;
		if (seen !== want) begin
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
			fail_count++;
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d errors=%0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ==========================================================
	// Note what the inputs sampled at this edge must give, then change them.
	task automatic step(input logic rst);
		ppfs_note_type n;
		logic [7:0] s1, s2, s3, od;
		logic [6:0] sj, sje, blk, pe;
		logic xt, bp, tm;
		@(posedge clock);
		s1 = p1_port_function_select_bit;
		s2 = p2_port_function_select_bit;
		s3 = p3_port_function_select_bit;
		sj = pj_port_function_select_bit;
		tm = test_port_mode;
		xt = sj[5] & !oscillator_bypass_enable;
		bp = sj[5] & oscillator_bypass_enable;
		// Port J pins held by the test port or oscillator; only 0-3 and 6 have a peripheral.
		blk = {1'h0, sj[5], xt, {4{tm}}};
		sje = sj & 7'h4f & ~blk;
		od = {2'h0, {2{serial_unit_b_i2c_mode}} & s1[5:4], 4'h0};
		n.p1oe = (s1 & 8'h3f & p1_periph_oe) | (~(s1 & 8'h3f) & p1_port_direction_bit);
		n.p1oe = (n.p1oe & ~od) | (od & p1_periph_oe & ~p1_periph_out);
		n.p1out = ((s1 & p1_periph_out) | (~s1 & p1_gpio_out)) & ~od & n.p1oe;
		n.p1gin = ~s1 & p1_pin_in;
		n.p1pin = s1 & ~p1_port_direction_bit & p1_pin_in;
		n.p2oe = p2_port_direction_bit;
		n.p2out = ((s2 & p2_periph_out) | (~s2 & p2_gpio_out)) & n.p2oe;
		n.p2gin = ~s2 & p2_pin_in;
		n.p2pin = s2 & ~n.p2oe & p2_event_input_enable & p2_pin_in;
		n.p3oe = p3_port_direction_bit;
		n.p3out = ((s3 & p3_periph_out) | (~s3 & p3_gpio_out)) & n.p3oe;
		n.p3gin = ~s3 & p3_pin_in;
		n.p3pin = s3 & ~n.p3oe & p3_event_input_enable & p3_pin_in;
		n.pjoe = {1'h0, pj_port_direction_bit & ~{1'h0, sj[5], xt, 4'h0}};
		if (tm) n.pjoe[3:0] = {3'h0, test_port_tdo_oe};
		pe = (sje & pj_periph_out) | (~sje & pj_gpio_out);
		if (tm) pe[0] = test_port_tdo_out;
		n.pjout = {1'h0, pe} & n.pjoe;
		n.pjgin = {1'h0, pj_pin_in & ~sje & ~blk};
		n.pjpin = {1'h0, sje & ~pj_port_direction_bit & pj_pin_in};
		n.pjpull = {1'h0, pj_pull_resistor_enable_bit | {3'h0, {3{tm}}, 1'h0}};
		n.misc = {serial_unit_b_spi_mode_req & !s1[0], pj_pin_in[3:1] & {3{tm}}, xt, bp,
			bp & pj_pin_in[5], pj_pin_in[5] & !sj[5]};
		if (!sys_rst) note_q.push_back(n);
		sys_rst <= rst;
		{p1_port_direction_bit, p1_port_function_select_bit, p1_gpio_out, p1_pin_in} <= $urandom;
		{p2_port_direction_bit, p2_port_function_select_bit, p2_gpio_out, p2_pin_in} <= $urandom;
		{p3_port_direction_bit, p3_port_function_select_bit, p3_gpio_out, p3_pin_in} <= $urandom;
		{pj_port_direction_bit, pj_port_function_select_bit, pj_pull_resistor_enable_bit,
			pj_gpio_out} <= 28'($urandom);
		{pj_pin_in, serial_unit_b_i2c_mode, serial_unit_b_spi_mode_req, test_port_mode,
			oscillator_bypass_enable} <= 11'($urandom);
	endtask
	// ==========================================================
	// Outputs settle by the falling edge; take the oldest note and compare.
	always @(negedge clock) begin
		ppfs_note_type n;
		if (note_q.size() > 0) begin
			n = note_q.pop_front();
			check(p1_pin_oe, n.p1oe);
			check(p1_pin_out & n.p1oe, n.p1out);
			check(p1_gpio_in, n.p1gin);
			check(p1_periph_in, n.p1pin);
			check(p2_pin_oe, n.p2oe);
			check(p2_pin_out & n.p2oe, n.p2out);
			check(p2_gpio_in, n.p2gin);
			check(p2_periph_in, n.p2pin);
			check(p3_pin_oe, n.p3oe);
			check(p3_pin_out & n.p3oe, n.p3out);
			check(p3_gpio_in, n.p3gin);
			check(p3_periph_in, n.p3pin);
			check({1'h0, pj_pin_oe}, n.pjoe);
			check({1'h0, pj_pin_out} & n.pjoe, n.pjout);
			check({1'h0, pj_gpio_in}, n.pjgin);
			check({1'h0, pj_periph_in}, n.pjpin);
			check({1'h0, pj_pull_enable}, n.pjpull);
			check({serial_unit_b_spi_mode, test_port_tck, test_port_tms, test_port_tdi,
				osc_crystal_mode, osc_bypass_mode, osc_ext_clock_in, pj_gpio_in[5]}, n.misc);
		end
	end
	// ==========================================================
	// Reset, random traffic, a reset in mid-run, more traffic, then the verdict.
	initial begin
		void'($urandom(38));
		repeat (5) step(1'h1);
		repeat (500) step(1'h0);
		repeat (2) step(1'h1);
		repeat (500) step(1'h0);
		@(negedge clock);
		@(negedge clock);
		print_verdict();
	end
endmodule
